// *** hdl/lsir_map.svh ***
`ifndef LSIR_MAP_SVH
`define LSIR_MAP_SVH
// register indices inside one port window (byte address = 4 * index)
`define LSIR_IDX_TRIM 7'h26
`define LSIR_IDX_SR 7'h28
`define LSIR_IDX_SRL 7'h2A
`define LSIR_IDX_SRIE 7'h2C
`define LSIR_IDX_RGLR 7'h2E
`define LSIR_IDX_CTRL 7'h32
// live and latched bit positions
`define LSIR_B_JAF 12
`define LSIR_B_JAE 11
`define LSIR_B_TDM 10
`define LSIR_B_TX_OUTPUT_OPEN_SHORT 9
`define LSIR_B_MASTER_CLOCK_LOST 8
`define LSIR_B_RGLC 5
`define LSIR_B_RX_PREAMP_ON 4
`define LSIR_B_RF1 3
`define LSIR_B_RF2 2
`define LSIR_B_RX_LOCK_LOST 1
`define LSIR_B_ANALOG_SIGNAL_LOSS 0
// port control fields
`define LSIR_B_PIE 0
`define LSIR_B_GIE 1
`define LSIR_B_LM 2
// implemented bits and reset values
`define LSIR_SR_MASK 16'h071F
`define LSIR_SRL_MASK 16'h1F3F
`define LSIR_RST_REG 16'h0000
`define LSIR_RST_TRIM 4'h0
// amplitude steps, two's complement, units of 1/8 percent
`define LSIR_AMP_UP1 9'h01E
`define LSIR_AMP_UP2 9'h03C
`define LSIR_AMP_UP3 9'h05A
`define LSIR_AMP_UP4 9'h078
`define LSIR_AMP_UP5 9'h0A0
`define LSIR_AMP_UP6 9'h0C8
`define LSIR_AMP_UP7 9'h0F0
`define LSIR_AMP_DN0 9'h19C
`define LSIR_AMP_DN1 9'h1B5
`define LSIR_AMP_DN2 9'h1CE
`define LSIR_AMP_DN3 9'h1E7
`endif

// *** hdl/lsir_pkg.sv ***
package lsir_pkg;
    // line standard; selects which reference clock is watched
    typedef enum logic [1:0] {
        LSIR_LM_DS3 = 2'h0,
        LSIR_LM_E3 = 2'h1,
        LSIR_LM_STS1 = 2'h2,
        LSIR_LM_STS1B = 2'h3
    } lsir_lm_type;
endpackage

// *** hdl/lsir_regs.sv ***
// Summary of operation
// - four-bit trim sets amplitude, 0000 nominal
// - codes 0001-0111 raise amplitude stepwise
// - codes 1000-1011 lower amplitude stepwise
// - 110X drives to internal current limit
// - 111X maximum, current limiting off
// - port window at index n*80h plus offset
// - live bit 10 shows driver fault
// - live bit 9 shows output open/short
// - live bit 8 shows reference clock missing
// - live bit 4 shows preamp on
// - live bits 3, 2 show receive failures
// - live bit 1 shows loss of lock
// - live bit 0 shows analog signal loss
// - latched bit 12 on buffer full or slip
// - latched bit 11 on buffer empty or slip
// - latched change bits set on either edge
// - latched bit 8 sets on rise only
// - latched bit 5 on gain change
// - interrupt needs bit, port, global enables
// - enable bit matches latched bit position
// - gain register shows live gain, low byte
// - gain is signed quarter-dB count
// - line mode picks the watched reference clock
//
// Implementation choice: the AHB-Lite register port.
`include "lsir_map.svh"
`timescale 1ns/1ns
`default_nettype none

module lsir_regs
    import lsir_pkg::*;
#(
    parameter logic [1:0] PORT_INDEX = 2'h0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic txDriverFault,
    input wire logic txOutputOpenShort,
    input wire logic [2:0] refClockMissing,
    input wire logic rxPreampOn,
    input wire logic rxFailureOne,
    input wire logic rxFailureTwo,
    input wire logic rxLockLost,
    input wire logic analogSignalLoss,
    input wire logic jitterBufFull,
    input wire logic jitterBufEmpty,
    input wire logic jitterBufSlip,
    input wire logic [7:0] rxGainValue,
    output logic irq,
    output logic [3:0] txWaveTrim,
    output logic [8:0] txAmpAdjust,
    output logic txAmpAtLimit,
    output logic txAmpLimitOff
);

    ////////////////////////////////////////////////////////////////////
    // bus front end
    logic dpValid_r;
    logic dpWrite_r;
    logic [6:0] dpIdx_r;
    logic hreadyout_r;
    logic [31:0] hrdata_r;
    logic addrTaken;
    logic addrHit;
    logic wrStrobe;
    logic [15:0] wrData;

    // port select sits above the 7-bit register index
    assign addrHit = (haddr[10:9] == PORT_INDEX) && (haddr[1:0] == 2'h0)
        && (hsize == 3'h2);
    assign addrTaken = hsel && htrans[1] && hready;
    assign wrStrobe = dpValid_r && dpWrite_r && hready;
    assign wrData = hwdata[15:0];

    // data phase tracking; misses are taken but ignored
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dpValid_r <= 1'b0;
            dpWrite_r <= 1'b0;
            dpIdx_r <= 7'h00;
        end else if (hready) begin
            dpValid_r <= addrTaken && addrHit;
            dpWrite_r <= hwrite;
            dpIdx_r <= haddr[8:2];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software registers
    logic [15:0] ctrl_r;
    logic [15:0] ie_r;
    logic [3:0] trim_r;
    lsir_lm_type lineMode;

    assign lineMode = lsir_lm_type'(ctrl_r[`LSIR_B_LM +: 2]);

    // control and enable registers, plain read/write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `LSIR_RST_REG;
            ie_r <= `LSIR_RST_REG;
            trim_r <= `LSIR_RST_TRIM;
        end else if (wrStrobe) begin
            case (dpIdx_r)
                `LSIR_IDX_CTRL: ctrl_r <= wrData & 16'h000F;
                `LSIR_IDX_SRIE: ie_r <= wrData & `LSIR_SRL_MASK;
                `LSIR_IDX_TRIM: trim_r <= wrData[3:0];
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // live status capture
    logic [15:0] liveNext;
    logic [15:0] live_r;
    logic [7:0] gain_r;

    // reference clock check follows the selected line standard
    always_comb begin
        liveNext = 16'h0000;
        liveNext[`LSIR_B_TDM] = txDriverFault;
        liveNext[`LSIR_B_TX_OUTPUT_OPEN_SHORT] = txOutputOpenShort;
        case (lineMode)
            LSIR_LM_DS3: liveNext[`LSIR_B_MASTER_CLOCK_LOST] = refClockMissing[0];
            LSIR_LM_E3: liveNext[`LSIR_B_MASTER_CLOCK_LOST] = refClockMissing[1];
            default: liveNext[`LSIR_B_MASTER_CLOCK_LOST] = refClockMissing[2];
        endcase
        liveNext[`LSIR_B_RX_PREAMP_ON] = rxPreampOn;
        liveNext[`LSIR_B_RF1] = rxFailureOne;
        liveNext[`LSIR_B_RF2] = rxFailureTwo;
        // lock detector hysteresis lives in the recovery loop
        liveNext[`LSIR_B_RX_LOCK_LOST] = rxLockLost;
        liveNext[`LSIR_B_ANALOG_SIGNAL_LOSS] = analogSignalLoss;
    end

    // one register stage; edges are found against this copy
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            live_r <= `LSIR_RST_REG;
            gain_r <= 8'h00;
        end else begin
            live_r <= liveNext;
            gain_r <= rxGainValue;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // latched events, write one to clear
    logic [15:0] evt;
    logic [15:0] clr;
    logic [15:0] lat_r;
    logic slipOrFull;
    logic slipOrEmpty;

    assign slipOrFull = jitterBufFull || jitterBufSlip;
    assign slipOrEmpty = jitterBufEmpty || jitterBufSlip;

    // change bits fire on either edge, clock loss on rise only
    always_comb begin
        evt = (liveNext ^ live_r) & 16'h061F;
        evt[`LSIR_B_MASTER_CLOCK_LOST] = liveNext[`LSIR_B_MASTER_CLOCK_LOST]
            && !live_r[`LSIR_B_MASTER_CLOCK_LOST];
        evt[`LSIR_B_RGLC] = rxGainValue != gain_r;
        evt[`LSIR_B_JAF] = slipOrFull;
        evt[`LSIR_B_JAE] = slipOrEmpty;
    end

    assign clr = (wrStrobe && dpIdx_r == `LSIR_IDX_SRL) ? wrData : 16'h0000;

    // set beats clear so an event in the clear cycle survives
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_r <= `LSIR_RST_REG;
        end else begin
            lat_r <= ((lat_r & ~clr) | evt) & `LSIR_SRL_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt gate: bit, port and global enables
    logic irq_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= (|(lat_r & ie_r)) && ctrl_r[`LSIR_B_PIE]
                && ctrl_r[`LSIR_B_GIE];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // amplitude trim decode
    logic [8:0] adj_r;
    logic atLimit_r;
    logic limitOff_r;

    // lowest bit is a don't-care for the two limit codes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            adj_r <= 9'h000;
            atLimit_r <= 1'b0;
            limitOff_r <= 1'b0;
        end else begin
            atLimit_r <= trim_r[3:1] == 3'h6;
            limitOff_r <= trim_r[3:1] == 3'h7;
            case (trim_r)
                4'h1: adj_r <= `LSIR_AMP_UP1;
                4'h2: adj_r <= `LSIR_AMP_UP2;
                4'h3: adj_r <= `LSIR_AMP_UP3;
                4'h4: adj_r <= `LSIR_AMP_UP4;
                4'h5: adj_r <= `LSIR_AMP_UP5;
                4'h6: adj_r <= `LSIR_AMP_UP6;
                4'h7: adj_r <= `LSIR_AMP_UP7;
                4'h8: adj_r <= `LSIR_AMP_DN0;
                4'h9: adj_r <= `LSIR_AMP_DN1;
                4'hA: adj_r <= `LSIR_AMP_DN2;
                4'hB: adj_r <= `LSIR_AMP_DN3;
                default: adj_r <= 9'h000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path: one wait state so a read sees the prior write
    logic [15:0] rdVal;

    always_comb begin
        case (dpIdx_r)
            `LSIR_IDX_SR: rdVal = live_r & `LSIR_SR_MASK;
            `LSIR_IDX_SRL: rdVal = lat_r;
            `LSIR_IDX_SRIE: rdVal = ie_r;
            // signed quarter-dB count, passed through untouched
            `LSIR_IDX_RGLR: rdVal = {8'h00, gain_r};
            `LSIR_IDX_TRIM: rdVal = {12'h000, trim_r};
            `LSIR_IDX_CTRL: rdVal = ctrl_r;
            default: rdVal = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout_r <= 1'b1;
            hrdata_r <= 32'h0000_0000;
        end else if (addrTaken && addrHit && !hwrite) begin
            hreadyout_r <= 1'b0;
        end else if (!hreadyout_r) begin
            hreadyout_r <= 1'b1;
            hrdata_r <= {16'h0000, rdVal};
        end
    end

    // response flop; only OKAY is given, registered so every output is a flop
    logic hresp_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hresp_r <= 1'b0;
        end else begin
            hresp_r <= 1'b0; // misses complete quietly, never as ERROR
        end
    end

    assign hreadyout = hreadyout_r;
    assign hrdata = hrdata_r;
    assign hresp = hresp_r;
    assign irq = irq_r;
    assign txWaveTrim = trim_r;
    assign txAmpAdjust = adj_r;
    assign txAmpAtLimit = atLimit_r;
    assign txAmpLimitOff = limitOff_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic clrLat0;
    assign clrLat0 = wrStrobe && dpIdx_r == `LSIR_IDX_SRL && wrData[0];

    chk_analog_signal_loss_change: assert property (
        $changed(live_r[`LSIR_B_ANALOG_SIGNAL_LOSS]) |-> lat_r[`LSIR_B_ANALOG_SIGNAL_LOSS])
        else $error("analog_signal_loss change not latched");

    chk_master_clock_lost_rise: assert property (
        $rose(live_r[`LSIR_B_MASTER_CLOCK_LOST]) |-> lat_r[`LSIR_B_MASTER_CLOCK_LOST])
        else $error("clock loss rise not latched");

    chk_master_clock_lost_fall: assert property (
        $fell(live_r[`LSIR_B_MASTER_CLOCK_LOST]) && !$past(lat_r[`LSIR_B_MASTER_CLOCK_LOST])
        |-> !lat_r[`LSIR_B_MASTER_CLOCK_LOST])
        else $error("clock loss fall latched");

    chk_gain_change: assert property (
        $changed(gain_r) |-> lat_r[`LSIR_B_RGLC])
        else $error("gain change not latched");

    chk_slip_both: assert property (
        jitterBufSlip |=> lat_r[`LSIR_B_JAF] && lat_r[`LSIR_B_JAE])
        else $error("slip did not set full and empty");

    chk_irq_gate: assert property (
        (|(lat_r & ie_r)) && ctrl_r[0] && ctrl_r[1] |=> irq)
        else $error("enabled event gave no interrupt");

    chk_irq_cause: assert property (
        irq |-> $past(ctrl_r[`LSIR_B_PIE] && ctrl_r[`LSIR_B_GIE]))
        else $error("interrupt without port or global enable");

    chk_w1c_clear: assert property (
        clrLat0 && !evt[0] |=> !lat_r[0])
        else $error("write one did not clear");

    chk_set_wins: assert property (
        clrLat0 && evt[0] |=> lat_r[0])
        else $error("event lost under clear");

    chk_trim_limit: assert property (
        trim_r[3:1] == 3'h6 |=> txAmpAtLimit && !txAmpLimitOff)
        else $error("current limit code not decoded");

    chk_trim_max: assert property (
        trim_r[3:1] == 3'h7 |=> txAmpLimitOff && txAmpAdjust == 9'h000)
        else $error("maximum code not decoded");

    chk_read_wait: assert property (
        addrTaken && addrHit && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    cov_read: cover property (addrTaken && addrHit && !hwrite);
    cov_irq: cover property ($rose(irq));
    cov_set_wins: cover property (clrLat0 && evt[0]);

endmodule

`default_nettype wire

// *** tb/lsir_host.sv ***
`timescale 1ns/1ns
`default_nettype none

// host side: single-word AHB-Lite master, one transfer at a time
module lsir_host (
    input wire logic core_clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // call just after a rising edge; returns just after the data-phase edge
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                        output logic [31:0] rd);
        int n;
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        n = 0;
        // bounded: a stuck bus gives up after 16 cycles per phase instead of hanging
        do begin
            @(posedge core_clk);
            n++;
        end while (hready !== 1'b1 && n < 16);
        htrans <= 2'h0;
        hwdata <= wd;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hready !== 1'b1 && n < 16);
        rd = hrdata;
    endtask
endmodule

`default_nettype wire

// *** tb/lsir_regs_tb.sv ***
`include "lsir_map.svh"
`timescale 1ns/1ns
`default_nettype none

module lsir_regs_tb;
    import lsir_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel, hwrite, hready, hresp, irq, atLim, limOff;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [2:0] refMiss = 3'h0;
    logic [6:0] live = 7'h00;
    logic jFull = 1'b0, jEmpty = 1'b0, jSlip = 1'b0;
    logic [7:0] gain = 8'h00, mGain = 8'h00;
    logic [3:0] trim, mCtrl = 4'h0;
    logic [8:0] amp;
    logic [15:0] seed = 16'h0869, mPrev = 16'h0000, mLat = 16'h0000, mIe = 16'h0000;
    int error_cnt = 0;
    int samples_checked = 0;
    logic [8:0] ampTab [16] = '{9'h000, 9'h01E, 9'h03C, 9'h05A, 9'h078, 9'h0A0, 9'h0C8, 9'h0F0,
        9'h19C, 9'h1B5, 9'h1CE, 9'h1E7, 9'h000, 9'h000, 9'h000, 9'h000};
    logic [6:0] regs [7] = '{`LSIR_IDX_TRIM, `LSIR_IDX_SR, `LSIR_IDX_SRL, `LSIR_IDX_SRIE,
        `LSIR_IDX_RGLR, `LSIR_IDX_CTRL, 7'h30};

    always #20 core_clk = ~core_clk;

    lsir_host host (.core_clk(core_clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    lsir_regs #(.PORT_INDEX(2'h0)) uut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
        .txDriverFault(live[6]), .txOutputOpenShort(live[5]), .refClockMissing(refMiss),
        .rxPreampOn(live[4]), .rxFailureOne(live[3]), .rxFailureTwo(live[2]),
        .rxLockLost(live[1]), .analogSignalLoss(live[0]), .jitterBufFull(jFull),
        .jitterBufEmpty(jEmpty), .jitterBufSlip(jSlip), .rxGainValue(gain), .irq(irq),
        .txWaveTrim(trim), .txAmpAdjust(amp), .txAmpAtLimit(atLim), .txAmpLimitOff(limOff));

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [31:0] adr(input logic [6:0] idx);
        return {23'h0, idx, 2'h0};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic rdc(input logic [6:0] idx, input logic [31:0] exp);
        host.xfer(1'b0, adr(idx), 32'h0, rd);
        chk(rd, exp);
        chk(32'(hresp), 32'h0);
    endtask

    task automatic wr(input logic [6:0] idx, input logic [15:0] d);
        host.xfer(1'b1, adr(idx), {16'h0, d}, rd);
    endtask

    // model: live word from inputs, latch edges; clock loss only latches on its rise
    task automatic upd;
        logic [15:0] n;
        n = {5'h0, live[6:5], refMiss[(mCtrl[3:2] > 2'h1) ? 2 : mCtrl[3:2]], 3'h0, live[4:0]};
        mLat |= ((n ^ mPrev) & 16'h061F) | (n & ~mPrev & 16'h0100);
        mLat |= (gain != mGain) ? 16'h0020 : 16'h0000;
        mPrev = n;
        mGain = gain;
    endtask

    function automatic logic [31:0] irqExp;
        return {31'h0, (|(mLat & mIe)) & mCtrl[0] & mCtrl[1]};
    endfunction

    task automatic close_out;
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the few hundred cycles the sequence needs
    initial begin
        #400000;
        error_cnt++;
        close_out();
    end

    // main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (regs[i]) rdc(regs[i], 32'h0);
        // every trim code, outputs checked after the readback lands
        for (int c = 0; c < 16; c++) begin
            wr(`LSIR_IDX_TRIM, 16'(c));
            rdc(`LSIR_IDX_TRIM, 32'(c));
            chk(32'(trim), 32'(c));
            chk(32'(amp), 32'(ampTab[c]));
            chk(32'(atLim), 32'(c / 2 == 6));
            chk(32'(limOff), 32'(c / 2 == 7));
        end
        // other port window and a misaligned address must not land
        host.xfer(1'b1, 32'h200 | adr(`LSIR_IDX_SRIE), 32'hFFFF, rd);
        host.xfer(1'b1, adr(`LSIR_IDX_SRIE) | 32'h1, 32'hFFFF, rd);
        rdc(`LSIR_IDX_SRIE, 32'h0);
        for (int k = 0; k < 14; k++) begin
            seed = lfsr(seed);
            wr(`LSIR_IDX_CTRL, {12'h0, seed[3:0]});
            mCtrl = seed[3:0];
            upd();
            rdc(`LSIR_IDX_CTRL, 32'(mCtrl));
            seed = lfsr(seed);
            wr(`LSIR_IDX_SRIE, seed);
            mIe = seed & `LSIR_SRL_MASK;
            seed = lfsr(seed);
            @(posedge core_clk);
            live <= seed[6:0];
            refMiss <= seed[9:7];
            gain <= seed[15:8];
            jFull <= seed[3];
            jEmpty <= seed[5];
            jSlip <= seed[12] & seed[0];
            @(posedge core_clk);
            upd();
            mLat |= {3'h0, jFull | jSlip, jEmpty | jSlip, 11'h0};
            jFull <= 1'b0;
            jEmpty <= 1'b0;
            jSlip <= 1'b0;
            @(posedge core_clk);
            rdc(`LSIR_IDX_SR, 32'(mPrev));
            rdc(`LSIR_IDX_SR, 32'(mPrev));
            rdc(`LSIR_IDX_SRL, 32'(mLat));
            rdc(`LSIR_IDX_RGLR, 32'(gain));
            rdc(`LSIR_IDX_SRIE, 32'(mIe));
            chk(32'(irq), irqExp());
            seed = lfsr(seed);
            wr(`LSIR_IDX_SRL, seed);
            mLat &= ~seed;
            rdc(`LSIR_IDX_SRL, 32'(mLat));
            chk(32'(irq), irqExp());
        end
        // a buffer-full level held across the clear keeps its bit
        @(posedge core_clk);
        jFull <= 1'b1;
        @(posedge core_clk);
        wr(`LSIR_IDX_SRL, 16'h1800);
        mLat = (mLat & 16'hE7FF) | 16'h1000;
        rdc(`LSIR_IDX_SRL, 32'(mLat));
        @(posedge core_clk);
        jFull <= 1'b0;
        @(posedge core_clk);
        wr(`LSIR_IDX_SRL, 16'hFFFF);
        rdc(`LSIR_IDX_SRL, 32'h0);
        close_out();
    end
endmodule

`default_nettype wire
